// ===== gpb_board_model.sv
// Board-side pin model: resolves every pad from design drive, board drive and pullups
module gpb_board_model
(
   // Pattern clock
   input  wire logic       pclk,
   // Design drive and pullups
   input  wire logic [7:0] b_out,
   input  wire logic [7:0] b_oe_n,
   input  wire logic [6:0] c_out,
   input  wire logic [6:0] c_oe_n,
   input  wire logic [6:0] c_pu,
   input  wire logic [7:0] d_out,
   input  wire logic [7:0] d_oe_n,
   input  wire logic [7:0] d_pu,
   // Board drive
   input  wire logic [7:0] ext_b,
   input  wire logic [7:0] ext_b_en,
   input  wire logic [7:0] ext_d,
   input  wire logic [7:0] ext_d_en,
   // Resolved pad levels
   output logic      [7:0] b_in,
   output logic      [6:0] c_in,
   output logic      [7:0] d_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic            flip_q = 1'b0;
   logic      [7:0] c_lvl;

   // A floating pad toggles each cycle so a stale level is never mistaken for a driven one
   always @(posedge pclk)
      flip_q <= ~flip_q;

   function automatic logic [7:0] pad(input logic [7:0] o, oe_n, pu, e, en, input logic t);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
      begin
         r[i] = !oe_n[i] ? o[i] : en[i] ? e[i] : pu[i] ? 1'b1 : t ^ i[0];
      end
      return r;
   endfunction

   assign b_in  = pad(b_out, b_oe_n, 8'h00, ext_b, ext_b_en, flip_q);
   assign c_lvl = pad({1'b0, c_out}, {1'b1, c_oe_n}, {1'b0, c_pu}, 8'h00, 8'h00, flip_q);
   assign c_in  = c_lvl[6:0];
   assign d_in  = pad(d_out, d_oe_n, d_pu, ext_d, ext_d_en, flip_q);
endmodule

// ===== gpb_pkg.sv
// Package of register indices, widths and field positions for the port B/C/D block
package gpb_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_B_LATCH  = 4'h1;
   localparam logic [3:0] IDX_C_LATCH  = 4'h2;
   localparam logic [3:0] IDX_D_LATCH  = 4'h3;
   localparam logic [3:0] IDX_B_DIR    = 4'h5;
   localparam logic [3:0] IDX_C_DIR    = 4'h6;
   localparam logic [3:0] IDX_D_DIR    = 4'h7;
   localparam logic [3:0] IDX_C_PULLUP = 4'h8;
   localparam logic [3:0] IDX_D_PULLUP = 4'h9;
   localparam int         IDX_LSB      = 2;
   localparam int         IDX_MSB      = 5;
   localparam int         ADDR_W       = 12;
   localparam int         DATA_W       = 32;
   // Port widths
   localparam int         B_W          = 8;
   localparam int         C_W          = 7;
   localparam int         D_W          = 8;
   // Converter channel field
   localparam int         ADC_CH_W     = 5;
   // Port D pin positions of shared functions
   localparam int         D_SEL_BIT    = 0;
   localparam int         D_MISO_BIT   = 1;
   localparam int         D_MOSI_BIT   = 2;
   localparam int         D_SCK_BIT    = 3;
   localparam int         D_T1_LO_BIT  = 4;
   localparam int         D_TMR_CH     = 4;
   // Reset values
   localparam logic [7:0] DIR_RST      = 8'h00;
   localparam logic [7:0] PULLUP_RST   = 8'h00;
endpackage

// ===== gpb_ports.sv
// Ports B, C and D: latches, direction, pullups, pin sharing and APB register slave
// Summary of operation
// - One writable latch per pin; reset leaves latch contents untouched.
// - Port B direction one enables the driver, zero makes the pin input.
// - Reset clears all port B direction bits.
// - Port B data read gives latch where output, synchronised pin where input.
// - Latch writes always accepted; for input pins readback still shows pin.
// - Converter channel selecting a port B pin forces it analog, overriding port.
// - Port C is seven bits; read gives latch for outputs, pin for inputs.
// - Reset clears port C direction; one selects output, zero input.
// - Port C pullup enable one connects the pullup, zero disconnects.
// - Port C pullup acts only while the pin is an input.
// - Timer two select fields give port D bits 6 and 7 to the timer.
// - Timer one select fields give port D bits 4 and 5 to the timer.
// - Serial clock and MOSI pins return to port use when interface disabled.
// - MISO pin on bit 1 serves the interface only while it is enabled.
// - Port D direction ignored on serial-owned pins but still picks read source.
// - Select pin bit 0 is port I/O when interface disabled or master.
// - While interface enabled as slave, direction bit 0 has no pin effect.
// - Port D data read gives latch for outputs, pin level for inputs.
// - Port D direction one drives the pin; reset clears all bits.
// - Port D pullup disabled whenever the pin is driven as output.
//
// The APB slave port was decided locally.
module gpb_ports
(
   // APB slave
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [gpb_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [gpb_pkg::DATA_W-1:0]  pwdata,
   output logic      [gpb_pkg::DATA_W-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Port B pins
   input  wire logic [gpb_pkg::B_W-1:0]     port_b_pin_in,
   output logic      [gpb_pkg::B_W-1:0]     port_b_pin_out,
   output logic      [gpb_pkg::B_W-1:0]     port_b_pin_oe_n,
   output logic      [gpb_pkg::B_W-1:0]     analog_input_pins,
   // Port C pins
   input  wire logic [gpb_pkg::C_W-1:0]     port_c_pin_in,
   output logic      [gpb_pkg::C_W-1:0]     port_c_pin_out,
   output logic      [gpb_pkg::C_W-1:0]     port_c_pin_oe_n,
   output logic      [gpb_pkg::C_W-1:0]     port_c_pullup_on,
   // Port D pins
   input  wire logic [gpb_pkg::D_W-1:0]     port_d_pin_in,
   output logic      [gpb_pkg::D_W-1:0]     port_d_pin_out,
   output logic      [gpb_pkg::D_W-1:0]     port_d_pin_oe_n,
   output logic      [gpb_pkg::D_W-1:0]     port_d_pullup_on,
   // Converter control
   input  wire logic                        adc_enable,
   input  wire logic [gpb_pkg::ADC_CH_W-1:0] adc_channel_sel,
   // Serial interface enable and master select
   input  wire logic                        serial_if_enable,
   input  wire logic                        serial_master_select,
   // Timer channel select fields, one pair per port D bit 4..7
   input  wire logic [gpb_pkg::D_TMR_CH-1:0] edge_level_select_high,
   input  wire logic [gpb_pkg::D_TMR_CH-1:0] edge_level_select_low,
   // Peripheral drive for port D pins, bit 0 unused
   input  wire logic [gpb_pkg::D_W-1:0]     periph_d_out,
   input  wire logic [gpb_pkg::D_W-1:0]     periph_d_oe,
   output logic      [gpb_pkg::D_W-1:0]     periph_d_in
);

   // Register state
   logic [gpb_pkg::B_W-1:0] port_b_output_latch;
   logic [gpb_pkg::C_W-1:0] port_c_output_latch;
   logic [gpb_pkg::D_W-1:0] port_d_output_latch;
   logic [gpb_pkg::B_W-1:0] port_b_direction_bits;
   logic [gpb_pkg::C_W-1:0] port_c_direction_bits;
   logic [gpb_pkg::D_W-1:0] port_d_direction_bits;
   logic [gpb_pkg::C_W-1:0] port_c_pullup_enables;
   logic [gpb_pkg::D_W-1:0] port_d_pullup_enables;

   // Pin synchronisers
   logic [gpb_pkg::B_W-1:0] pin_b_meta_q;
   logic [gpb_pkg::B_W-1:0] pin_b_q;
   logic [gpb_pkg::C_W-1:0] pin_c_meta_q;
   logic [gpb_pkg::C_W-1:0] pin_c_q;
   logic [gpb_pkg::D_W-1:0] pin_d_meta_q;
   logic [gpb_pkg::D_W-1:0] pin_d_q;

   // Bus decode
   logic [3:0]  idx;
   logic        setup_ph;
   logic        wr_en;
   logic        hit;
   logic        wr_b_latch;
   logic        wr_c_latch;
   logic        wr_d_latch;
   logic        wr_b_dir;
   logic        wr_c_dir;
   logic        wr_d_dir;
   logic        wr_c_pu;
   logic        wr_d_pu;
   logic [31:0] rd_mux;

   assign idx        = paddr[gpb_pkg::IDX_MSB:gpb_pkg::IDX_LSB];
   assign setup_ph   = psel & ~penable;
   assign wr_en      = psel & penable & pready & pwrite & ~pslverr;
   assign wr_b_latch = wr_en & (idx == gpb_pkg::IDX_B_LATCH);
   assign wr_c_latch = wr_en & (idx == gpb_pkg::IDX_C_LATCH);
   assign wr_d_latch = wr_en & (idx == gpb_pkg::IDX_D_LATCH);
   assign wr_b_dir   = wr_en & (idx == gpb_pkg::IDX_B_DIR);
   assign wr_c_dir   = wr_en & (idx == gpb_pkg::IDX_C_DIR);
   assign wr_d_dir   = wr_en & (idx == gpb_pkg::IDX_D_DIR);
   assign wr_c_pu    = wr_en & (idx == gpb_pkg::IDX_C_PULLUP);
   assign wr_d_pu    = wr_en & (idx == gpb_pkg::IDX_D_PULLUP);

   // Read sources: latch where output, pin where input
   logic [gpb_pkg::B_W-1:0] rd_b;
   logic [gpb_pkg::C_W-1:0] rd_c;
   logic [gpb_pkg::D_W-1:0] rd_d;
   assign rd_b = (port_b_direction_bits & port_b_output_latch)
               | (~port_b_direction_bits & pin_b_q);
   assign rd_c = (port_c_direction_bits & port_c_output_latch)
               | (~port_c_direction_bits & pin_c_q);
   // Direction still picks the read source on serial- and timer-owned pins
   assign rd_d = (port_d_direction_bits & port_d_output_latch)
               | (~port_d_direction_bits & pin_d_q);

   assign hit = (paddr[gpb_pkg::ADDR_W-1:gpb_pkg::IDX_MSB+1] == '0)
              & (paddr[gpb_pkg::IDX_LSB-1:0] == '0)
              & ((idx == gpb_pkg::IDX_B_LATCH) | (idx == gpb_pkg::IDX_C_LATCH)
               | (idx == gpb_pkg::IDX_D_LATCH) | (idx == gpb_pkg::IDX_B_DIR)
               | (idx == gpb_pkg::IDX_C_DIR)   | (idx == gpb_pkg::IDX_D_DIR)
               | (idx == gpb_pkg::IDX_C_PULLUP) | (idx == gpb_pkg::IDX_D_PULLUP));

   always_comb
   begin
      rd_mux = '0;
      unique case (idx)
         gpb_pkg::IDX_B_LATCH:  rd_mux[gpb_pkg::B_W-1:0] = rd_b;
         gpb_pkg::IDX_C_LATCH:  rd_mux[gpb_pkg::C_W-1:0] = rd_c;
         gpb_pkg::IDX_D_LATCH:  rd_mux[gpb_pkg::D_W-1:0] = rd_d;
         gpb_pkg::IDX_B_DIR:    rd_mux[gpb_pkg::B_W-1:0] = port_b_direction_bits;
         gpb_pkg::IDX_C_DIR:    rd_mux[gpb_pkg::C_W-1:0] = port_c_direction_bits;
         gpb_pkg::IDX_D_DIR:    rd_mux[gpb_pkg::D_W-1:0] = port_d_direction_bits;
         gpb_pkg::IDX_C_PULLUP: rd_mux[gpb_pkg::C_W-1:0] = port_c_pullup_enables;
         gpb_pkg::IDX_D_PULLUP: rd_mux[gpb_pkg::D_W-1:0] = port_d_pullup_enables;
         default:               rd_mux = '0;
      endcase
   end

   // Answer in the first access cycle; data captured at the setup edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~hit;
         if (setup_ph)
            prdata <= (hit & ~pwrite) ? rd_mux : '0;
      end
   end

   // Latches have no reset so contents survive a system reset
   always_ff @(posedge pclk)
   begin
      if (wr_b_latch)
         port_b_output_latch <= pwdata[gpb_pkg::B_W-1:0];
      if (wr_c_latch)
         port_c_output_latch <= pwdata[gpb_pkg::C_W-1:0];
      if (wr_d_latch)
         port_d_output_latch <= pwdata[gpb_pkg::D_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_b_direction_bits <= gpb_pkg::DIR_RST;
         port_c_direction_bits <= gpb_pkg::DIR_RST[gpb_pkg::C_W-1:0];
         port_d_direction_bits <= gpb_pkg::DIR_RST;
         port_c_pullup_enables <= gpb_pkg::PULLUP_RST[gpb_pkg::C_W-1:0];
         port_d_pullup_enables <= gpb_pkg::PULLUP_RST;
      end
      else
      begin
         if (wr_b_dir)
            port_b_direction_bits <= pwdata[gpb_pkg::B_W-1:0];
         if (wr_c_dir)
            port_c_direction_bits <= pwdata[gpb_pkg::C_W-1:0];
         if (wr_d_dir)
            port_d_direction_bits <= pwdata[gpb_pkg::D_W-1:0];
         if (wr_c_pu)
            port_c_pullup_enables <= pwdata[gpb_pkg::C_W-1:0];
         if (wr_d_pu)
            port_d_pullup_enables <= pwdata[gpb_pkg::D_W-1:0];
      end
   end

   // Two-stage synchronisers; only the second stage feeds logic
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_b_meta_q <= '0;
         pin_b_q      <= '0;
         pin_c_meta_q <= '0;
         pin_c_q      <= '0;
         pin_d_meta_q <= '0;
         pin_d_q      <= '0;
      end
      else
      begin
         pin_b_meta_q <= port_b_pin_in;
         pin_b_q      <= pin_b_meta_q;
         pin_c_meta_q <= port_c_pin_in;
         pin_c_q      <= pin_c_meta_q;
         pin_d_meta_q <= port_d_pin_in;
         pin_d_q      <= pin_d_meta_q;
      end
   end

   // Port D ownership by shared peripherals
   logic [gpb_pkg::D_W-1:0] d_owned;
   logic [gpb_pkg::D_W-1:0] d_drive_en;
   logic [gpb_pkg::D_W-1:0] d_drive_val;
   logic [gpb_pkg::B_W-1:0] b_analog;
   logic [gpb_pkg::B_W-1:0] b_drive_en;
   logic [gpb_pkg::C_W-1:0] c_pull;
   logic [gpb_pkg::D_W-1:0] d_pull;

   // Select pin is a slave input only; master mode hands it back to the port
   assign d_owned[gpb_pkg::D_SEL_BIT]  = serial_if_enable & ~serial_master_select;
   assign d_owned[gpb_pkg::D_MISO_BIT] = serial_if_enable;
   assign d_owned[gpb_pkg::D_MOSI_BIT] = serial_if_enable;
   assign d_owned[gpb_pkg::D_SCK_BIT]  = serial_if_enable;

   genvar g;
   generate
      for (g = 0; g < gpb_pkg::D_TMR_CH; g++)
      begin : g_tmr
         // Any nonzero select field gives the pin to the timer channel
         assign d_owned[gpb_pkg::D_T1_LO_BIT+g] =
            edge_level_select_high[g] | edge_level_select_low[g];
      end
      for (g = 0; g < gpb_pkg::D_W; g++)
      begin : g_d
         assign d_drive_en[g]  = d_owned[g] ? (periph_d_oe[g] & (g != gpb_pkg::D_SEL_BIT))
                                            : port_d_direction_bits[g];
         assign d_drive_val[g] = d_owned[g] ? periph_d_out[g]
                                            : port_d_output_latch[g];
      end
      for (g = 0; g < gpb_pkg::B_W; g++)
      begin : g_b
         assign b_analog[g] = adc_enable
                            & (adc_channel_sel == gpb_pkg::ADC_CH_W'(g));
      end
   endgenerate

   assign b_drive_en = port_b_direction_bits & ~b_analog;
   assign c_pull     = port_c_pullup_enables & ~port_c_direction_bits;
   assign d_pull     = port_d_pullup_enables & ~d_drive_en;

   // Registered pin drivers; a one-cycle lag after register writes is accepted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_b_pin_out    <= '0;
         port_b_pin_oe_n   <= '1;
         analog_input_pins <= '0;
         port_c_pin_out    <= '0;
         port_c_pin_oe_n   <= '1;
         port_c_pullup_on  <= '0;
         port_d_pin_out    <= '0;
         port_d_pin_oe_n   <= '1;
         port_d_pullup_on  <= '0;
         periph_d_in       <= '0;
      end
      else
      begin
         port_b_pin_out    <= port_b_output_latch;
         port_b_pin_oe_n   <= ~b_drive_en;
         analog_input_pins <= b_analog;
         port_c_pin_out    <= port_c_output_latch;
         port_c_pin_oe_n   <= ~port_c_direction_bits;
         port_c_pullup_on  <= c_pull;
         port_d_pin_out    <= d_drive_val;
         port_d_pin_oe_n   <= ~d_drive_en;
         port_d_pullup_on  <= d_pull;
         periph_d_in       <= pin_d_q;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_latch_write;
      wr_b_latch |=> port_b_output_latch == $past(pwdata[gpb_pkg::B_W-1:0]);
   endproperty
   a_latch_write: assert property (p_latch_write)
      else $error("port B latch missed a write");

   property p_dir_hold;
      !wr_b_dir |=> $stable(port_b_direction_bits);
   endproperty
   a_dir_hold: assert property (p_dir_hold)
      else $error("port B direction changed without a write");

   property p_b_drive;
      ##1 port_b_pin_oe_n == ~($past(port_b_direction_bits) & ~$past(b_analog));
   endproperty
   a_b_drive: assert property (p_b_drive)
      else $error("port B enable does not follow direction");

   property p_b_analog;
      b_analog != '0 |=> (port_b_pin_oe_n & analog_input_pins) == analog_input_pins;
   endproperty
   a_b_analog: assert property (p_b_analog)
      else $error("analog pin still driven");

   property p_read_b;
      setup_ph & ~pwrite & (idx == gpb_pkg::IDX_B_LATCH) & hit
         |=> pready & (prdata[gpb_pkg::B_W-1:0] == $past(rd_b));
   endproperty
   a_read_b: assert property (p_read_b)
      else $error("port B read wrong");

   property p_read_c;
      setup_ph & ~pwrite & (idx == gpb_pkg::IDX_C_LATCH) & hit
         |=> prdata[gpb_pkg::C_W-1:0] == $past(rd_c);
   endproperty
   a_read_c: assert property (p_read_c)
      else $error("port C read wrong");

   property p_c_pull;
      ##1 (port_c_pullup_on & ~port_c_pin_oe_n) == '0;
   endproperty
   a_c_pull: assert property (p_c_pull)
      else $error("port C pullup on a driven pin");

   property p_spi_off;
      !serial_if_enable & !(edge_level_select_high[0] | edge_level_select_low[0])
         |=> port_d_pin_oe_n[gpb_pkg::D_T1_LO_BIT:0]
             == ~$past(port_d_direction_bits[gpb_pkg::D_T1_LO_BIT:0]);
   endproperty
   a_spi_off: assert property (p_spi_off)
      else $error("port D pins not released with interface off");

   property p_sel_slave;
      serial_if_enable & !serial_master_select |=> port_d_pin_oe_n[gpb_pkg::D_SEL_BIT];
   endproperty
   a_sel_slave: assert property (p_sel_slave)
      else $error("select pin driven in slave mode");

   property p_periph_prio;
      d_owned[gpb_pkg::D_MISO_BIT] |=>
         port_d_pin_out[gpb_pkg::D_MISO_BIT] == $past(periph_d_out[gpb_pkg::D_MISO_BIT]);
   endproperty
   a_periph_prio: assert property (p_periph_prio)
      else $error("peripheral value lost priority");

   property p_d_pull;
      ##1 (port_d_pullup_on & ~port_d_pin_oe_n) == '0;
   endproperty
   a_d_pull: assert property (p_d_pull)
      else $error("port D pullup on a driven pin");

endmodule

// ===== test_gpio_ports_b_c_d.sv
// Self-checking bench for the port B/C/D block over APB
module test_gpio_ports_b_c_d;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  b_in, b_out, b_oe_n, analog, ext_b = 8'h00, ext_b_en = 8'h00;
   logic [6:0]  c_in, c_out, c_oe_n, c_pu;
   logic [7:0]  d_in, d_out, d_oe_n, d_pu, d_pin_in, ext_d = 8'h00, ext_d_en = 8'h00;
   logic        adc_enable = 1'b0, ser_en = 1'b0, ser_mst = 1'b0;
   logic [4:0]  adc_sel = 5'h00;
   logic [3:0]  els_hi = 4'h0, els_lo = 4'h0;
   logic [7:0]  pd_out = 8'h00, pd_oe = 8'h00;
   int          fails = 0, checks_done = 0, cycles = 0;

   gpb_ports gpb_ports_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_b_pin_in(b_in), .port_b_pin_out(b_out),
      .port_b_pin_oe_n(b_oe_n), .analog_input_pins(analog), .port_c_pin_in(c_in),
      .port_c_pin_out(c_out), .port_c_pin_oe_n(c_oe_n), .port_c_pullup_on(c_pu),
      .port_d_pin_in(d_in), .port_d_pin_out(d_out), .port_d_pin_oe_n(d_oe_n),
      .port_d_pullup_on(d_pu), .adc_enable(adc_enable), .adc_channel_sel(adc_sel),
      .serial_if_enable(ser_en), .serial_master_select(ser_mst),
      .edge_level_select_high(els_hi), .edge_level_select_low(els_lo),
      .periph_d_out(pd_out), .periph_d_oe(pd_oe), .periph_d_in(d_pin_in));

   gpb_board_model gpb_board_model_i (.pclk(pclk), .b_out(b_out), .b_oe_n(b_oe_n),
      .c_out(c_out), .c_oe_n(c_oe_n), .c_pu(c_pu), .d_out(d_out), .d_oe_n(d_oe_n),
      .d_pu(d_pu), .ext_b(ext_b), .ext_b_en(ext_b_en), .ext_d(ext_d), .ext_d_en(ext_d_en),
      .b_in(b_in), .c_in(c_in), .d_in(d_in));

   initial
   begin
      forever #10 pclk = ~pclk;
   end

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Cuts a hung run short; every wait below is bounded by it
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Returns on a rising edge so the next stimulus is launched there; the flops
   // read here still hold what the previous edge gave them
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [11:0] ad(input logic [3:0] idx);
      return {6'h00, idx, 2'b00};
   endfunction

   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, ad(idx), d, r, e);
      chk(32'(e), 32'h0);
   endtask

   task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      xfer(1'b0, ad(idx), 32'h0, r, e);
      chk(r, exp);
      chk(32'(e), 32'h0);
   endtask

   initial
   begin
      logic [31:0] r;
      logic        e;
      logic [3:0]  rst_idx [5];
      rst_idx = '{gpb_pkg::IDX_B_DIR, gpb_pkg::IDX_C_DIR, gpb_pkg::IDX_D_DIR,
                  gpb_pkg::IDX_C_PULLUP, gpb_pkg::IDX_D_PULLUP};
      do_reset();
      for (int i = 0; i < 5; i++)
         rdchk(rst_idx[i], 32'h0);
      chk(32'(b_oe_n), 32'hff);
      // Port B: input reads the pad, latch write still accepted
      ext_b    <= 8'h5a;
      ext_b_en <= 8'hff;
      wr(gpb_pkg::IDX_B_LATCH, 32'hffffffa5);
      settle(4);
      rdchk(gpb_pkg::IDX_B_LATCH, 32'h5a);
      wr(gpb_pkg::IDX_B_DIR, 32'h0f);
      settle(4);
      chk(32'(b_oe_n), 32'hf0);
      chk(32'(b_out & 8'h0f), 32'h05);
      rdchk(gpb_pkg::IDX_B_LATCH, 32'h55);
      wr(gpb_pkg::IDX_B_DIR, 32'hff);
      adc_enable <= 1'b1;
      for (int g = 0; g < 9; g++)
      begin
         adc_sel <= 5'(g);
         settle(2);
         chk(32'(analog), (g < 8) ? (32'h1 << g) : 32'h0);
         chk(32'(b_oe_n), (g < 8) ? (32'h1 << g) : 32'h0);
      end
      adc_enable <= 1'b0;
      // Latch contents must survive a reset in mid-run
      do_reset();
      rdchk(gpb_pkg::IDX_B_DIR, 32'h0);
      ext_b_en <= 8'h00;
      wr(gpb_pkg::IDX_B_DIR, 32'hff);
      settle(4);
      rdchk(gpb_pkg::IDX_B_LATCH, 32'ha5);
      // Port C pullups follow direction
      wr(gpb_pkg::IDX_C_LATCH, 32'h05);
      wr(gpb_pkg::IDX_C_PULLUP, 32'h7f);
      settle(4);
      chk(32'(c_pu), 32'h7f);
      rdchk(gpb_pkg::IDX_C_LATCH, 32'h7f);
      wr(gpb_pkg::IDX_C_DIR, 32'h0f);
      settle(4);
      chk(32'(c_pu), 32'h70);
      chk(32'(c_oe_n), 32'h70);
      chk(32'(c_out), 32'h05);
      rdchk(gpb_pkg::IDX_C_LATCH, 32'h75);
      wr(gpb_pkg::IDX_C_PULLUP, 32'h0);
      settle(2);
      chk(32'(c_pu), 32'h0);
      // Port D sharing with serial interface and timers
      wr(gpb_pkg::IDX_D_LATCH, 32'h3c);
      wr(gpb_pkg::IDX_D_DIR, 32'hff);
      settle(2);
      chk(32'(d_oe_n), 32'h00);
      chk(32'(d_out), 32'h3c);
      ser_en <= 1'b1;
      pd_oe  <= 8'h02;
      pd_out <= 8'h02;
      settle(2);
      chk(32'(d_oe_n), 32'h0d);
      chk(32'(d_out & 8'h02), 32'h02);
      rdchk(gpb_pkg::IDX_D_LATCH, 32'h3c);
      ser_mst <= 1'b1;
      settle(2);
      chk(32'(d_oe_n), 32'h0c);
      ser_en  <= 1'b0;
      ser_mst <= 1'b0;
      els_hi  <= 4'b0001;
      els_lo  <= 4'b1000;
      pd_oe   <= 8'h10;
      pd_out  <= 8'h00;
      settle(2);
      chk(32'(d_oe_n), 32'h80);
      chk(32'(d_out & 8'h10), 32'h0);
      els_hi   <= 4'h0;
      els_lo   <= 4'h0;
      pd_oe    <= 8'h00;
      ext_d    <= 8'ha5;
      ext_d_en <= 8'hf0;
      wr(gpb_pkg::IDX_D_DIR, 32'h0f);
      wr(gpb_pkg::IDX_D_PULLUP, 32'hff);
      settle(4);
      chk(32'(d_pu), 32'hf0);
      rdchk(gpb_pkg::IDX_D_LATCH, 32'hac);
      chk(32'(d_pin_in), 32'hac);
      // Unmapped and misaligned places are refused
      xfer(1'b1, 12'h02c, 32'hff, r, e);
      chk(32'(e), 32'h1);
      xfer(1'b0, 12'h02c, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      xfer(1'b0, 12'h005, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      end_sim();
   end
endmodule
